// File: core/srrc_pkg.sv
package srrc_pkg;

	// clock and hot-plug reset timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int HOTPLUG_RESET_US = 100;
	// least time, rounded up to whole cycles
	localparam int HOTPLUG_RESET_CYCLES =
		(HOTPLUG_RESET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// transmit pair positions on the four-pair serial bus
	localparam int TX_PAIRS = 4;
	localparam int TX_UP_LANE0_IDX = 0;
	localparam int TX_DN_PORT1_IDX = 1;
	localparam int TX_DN_PORT2_IDX = 2;
	localparam int TX_UP_LANE1_IDX = 3;

	// downstream ports and reference clock outputs
	localparam int DN_PORT_LO = 1;
	localparam int DN_PORT_HI = 2;
	localparam int REFCLK_OUTS = 3;

	// values after reset
	localparam logic DS_RESET_N_RST = 1'b0;
	localparam logic CORE_RESET_N_RST = 1'b0;
	localparam logic STRAP_PD_RST = 1'b1;
	localparam logic PRESENT_N_RST = 1'b1;
	localparam logic TX_IDLE = 1'b0;

	typedef enum logic [2:0] {
		SRRC_ST_FUND = 3'b001,
		SRRC_ST_HOLD = 3'b010,
		SRRC_ST_RUN  = 3'b100
	} srrc_port_st_t;

	// transmit data presented by the port logic, one bit per lane
	typedef struct packed {
		logic [1:0] up_lane;
		logic dn_port2;
		logic dn_port1;
	} srrc_tx_t;

endpackage

// File: core/srrc_port_reset.sv
module srrc_port_reset #(
	parameter int HOLD_CYCLES = srrc_pkg::HOTPLUG_RESET_CYCLES,
	parameter int CNT_W = $clog2(HOLD_CYCLES + 1)
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_fund_active,
	input wire logic i_present_n,
	output logic o_reset_n,
	output logic o_plug_event
);

	srrc_pkg::srrc_port_st_t state_r;
	srrc_pkg::srrc_port_st_t state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic present_n_r;
	logic plug;

	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);

	// a slot going from empty to present is a fresh plug-in
	assign plug = present_n_r & ~i_present_n;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			present_n_r <= srrc_pkg::PRESENT_N_RST;
		end else begin
			present_n_r <= i_present_n;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			srrc_pkg::SRRC_ST_FUND: begin
				// a plug-in in the release cycle must not be lost
				if (!i_fund_active && plug) begin
					state_nxt = srrc_pkg::SRRC_ST_HOLD;
				end else if (!i_fund_active) begin
					state_nxt = srrc_pkg::SRRC_ST_RUN;
				end
			end
			srrc_pkg::SRRC_ST_RUN: begin
				if (i_fund_active) begin
					state_nxt = srrc_pkg::SRRC_ST_FUND;
				end else if (plug) begin
					state_nxt = srrc_pkg::SRRC_ST_HOLD;
				end
			end
			srrc_pkg::SRRC_ST_HOLD: begin
				if (i_fund_active) begin
					state_nxt = srrc_pkg::SRRC_ST_FUND;
				end else if (cnt_r == '0 && !plug) begin
					state_nxt = srrc_pkg::SRRC_ST_RUN;
				end
			end
			default: begin
				state_nxt = srrc_pkg::SRRC_ST_FUND;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_r <= srrc_pkg::SRRC_ST_FUND;
			o_reset_n <= srrc_pkg::DS_RESET_N_RST;
		end else begin
			state_r <= state_nxt;
			o_reset_n <= (state_nxt == srrc_pkg::SRRC_ST_RUN);
		end
	end

	// hold count restarts on every new plug-in
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cnt_r <= '0;
		end else if (plug) begin
			cnt_r <= HOLD_LAST;
		end else if (state_r == srrc_pkg::SRRC_ST_HOLD && cnt_r != '0) begin
			cnt_r <= cnt_r - CNT_W'(1);
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_plug_event <= 1'b0;
		end else begin
			o_plug_event <= plug;
		end
	end

endmodule

// File: core/srrc_top.sv
// Functional notes
// - fundamental reset low initializes all internal state; sticky bits survive it. the port logic does not clear cnt_r, present_n_r or o_plug_event under it.
// - fundamental reset asserted drives every downstream reset output low.
// - a fresh plug-in on a downstream port asserts that port's reset output.
// - two downstream reset outputs, bit x serves downstream port x, x=1,2.
// - power-down strap sampled high disables the clock buffer and its outputs.
// - power-down strap low enables the clock buffer and drives its outputs.
// - upstream lane 0 goes on pair 0, upstream lane 1 on pair 3.
// - downstream port 1 goes on pair 1, port 2 on pair 2.
module srrc_top #(
	parameter int HOTPLUG_HOLD_CYCLES = srrc_pkg::HOTPLUG_RESET_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_fundamental_reset_n,
	input wire logic i_refclk_buffer_powerdown,
	input wire logic [2:1] i_slot_present_n,
	input wire srrc_pkg::srrc_tx_t i_tx,
	output logic o_core_reset_n,
	output logic [2:1] o_downstream_port_reset_n,
	output logic [2:1] o_plug_seen,
	output logic o_refclk_buffer_enable,
	output logic [2:0] o_refclk_out_enable,
	output logic [3:0] o_serial_tx_pos,
	output logic [3:0] o_serial_tx_neg
);

	logic fund_active_r;
	logic strap_pd_r;
	logic [2:1] plug_event;

	// fundamental reset level, taken once so all users see the same cycle
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			fund_active_r <= 1'b1;
		end else begin
			fund_active_r <= ~i_fundamental_reset_n;
		end
	end

	// non-sticky state of the rest of the chip follows the fundamental reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_core_reset_n <= srrc_pkg::CORE_RESET_N_RST;
		end else begin
			o_core_reset_n <= ~fund_active_r;
		end
	end

	// per-port reset generation
	genvar g;
	generate
		for (g = srrc_pkg::DN_PORT_LO; g <= srrc_pkg::DN_PORT_HI; g++) begin : g_port
			srrc_port_reset #(
				.HOLD_CYCLES(HOTPLUG_HOLD_CYCLES)
			) u_port (
				.i_clk(i_clk),
				.i_reset(i_reset),
				.i_fund_active(fund_active_r),
				.i_present_n(i_slot_present_n[g]),
				.o_reset_n(o_downstream_port_reset_n[g]),
				.o_plug_event(plug_event[g])
			);

			// sticky: only the power-on reset clears it, never the fundamental one
			always_ff @(posedge i_clk or posedge i_reset) begin
				if (i_reset) begin
					o_plug_seen[g] <= 1'b0;
				end else if (plug_event[g]) begin
					o_plug_seen[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// strap is followed while the fundamental reset holds, frozen after release
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			strap_pd_r <= srrc_pkg::STRAP_PD_RST;
		end else if (fund_active_r) begin
			strap_pd_r <= i_refclk_buffer_powerdown;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_refclk_buffer_enable <= 1'b0;
			o_refclk_out_enable <= 3'h0;
		end else begin
			o_refclk_buffer_enable <= ~strap_pd_r;
			o_refclk_out_enable <= {srrc_pkg::REFCLK_OUTS{~strap_pd_r}};
		end
	end

	// transmit lane placement; pairs idle while the fundamental reset holds
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_serial_tx_pos <= {srrc_pkg::TX_PAIRS{srrc_pkg::TX_IDLE}};
			o_serial_tx_neg <= {srrc_pkg::TX_PAIRS{srrc_pkg::TX_IDLE}};
		end else if (fund_active_r) begin
			o_serial_tx_pos <= {srrc_pkg::TX_PAIRS{srrc_pkg::TX_IDLE}};
			o_serial_tx_neg <= {srrc_pkg::TX_PAIRS{srrc_pkg::TX_IDLE}};
		end else begin
			o_serial_tx_pos[srrc_pkg::TX_UP_LANE0_IDX] <= i_tx.up_lane[0];
			o_serial_tx_pos[srrc_pkg::TX_UP_LANE1_IDX] <= i_tx.up_lane[1];
			o_serial_tx_pos[srrc_pkg::TX_DN_PORT1_IDX] <= i_tx.dn_port1;
			o_serial_tx_pos[srrc_pkg::TX_DN_PORT2_IDX] <= i_tx.dn_port2;
			o_serial_tx_neg[srrc_pkg::TX_UP_LANE0_IDX] <= ~i_tx.up_lane[0];
			o_serial_tx_neg[srrc_pkg::TX_UP_LANE1_IDX] <= ~i_tx.up_lane[1];
			o_serial_tx_neg[srrc_pkg::TX_DN_PORT1_IDX] <= ~i_tx.dn_port1;
			o_serial_tx_neg[srrc_pkg::TX_DN_PORT2_IDX] <= ~i_tx.dn_port2;
		end
	end

	a_core_reset_follow: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!i_fundamental_reset_n |=> ##1 !o_core_reset_n
	) else $error("core reset not asserted two cycles after fundamental reset");

	a_core_reset_release: assert property (
		@(posedge i_clk) disable iff (i_reset)
		i_fundamental_reset_n |=> ##1 o_core_reset_n
	) else $error("core reset not released two cycles after fundamental release");

	a_sticky_survives: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_plug_seen[1] |=> o_plug_seen[1]
	) else $error("sticky plug flag lost without power-on reset");

	a_fund_all_ports: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!i_fundamental_reset_n |=> ##1 (o_downstream_port_reset_n == 2'h0)
	) else $error("downstream resets not both low under fundamental reset");

	a_plug_port1: assert property (
		@(posedge i_clk) disable iff (i_reset)
		($fell(i_slot_present_n[1]) && !fund_active_r && i_fundamental_reset_n)
			|=> !o_downstream_port_reset_n[1]
	) else $error("port 1 reset not asserted after plug-in");

	a_port_separate: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(i_fundamental_reset_n && !fund_active_r && o_downstream_port_reset_n[2]
			&& $fell(i_slot_present_n[1]) && !$fell(i_slot_present_n[2]))
			|=> o_downstream_port_reset_n[2]
	) else $error("port 1 plug-in disturbed port 2 reset");

	a_strap_high_off: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(fund_active_r && i_refclk_buffer_powerdown)
			|=> ##1 (!o_refclk_buffer_enable && o_refclk_out_enable == 3'h0)
	) else $error("clock buffer not disabled with power-down strap high");

	a_strap_low_on: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(fund_active_r && !i_refclk_buffer_powerdown)
			|=> ##1 (o_refclk_buffer_enable && o_refclk_out_enable == 3'h7)
	) else $error("clock buffer not enabled with power-down strap low");

	a_strap_frozen: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(!fund_active_r && $past(!fund_active_r)) |=> $stable(o_refclk_buffer_enable)
	) else $error("clock buffer enable changed outside fundamental reset");

	a_tx_upstream: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!fund_active_r |=> (o_serial_tx_pos[0] == $past(i_tx.up_lane[0])
			&& o_serial_tx_pos[3] == $past(i_tx.up_lane[1])
			&& o_serial_tx_neg[3] == ~o_serial_tx_pos[3])
	) else $error("upstream lanes not on pairs 0 and 3");

	a_tx_downstream: assert property (
		@(posedge i_clk) disable iff (i_reset)
		!fund_active_r |=> (o_serial_tx_pos[1] == $past(i_tx.dn_port1)
			&& o_serial_tx_pos[2] == $past(i_tx.dn_port2)
			&& o_serial_tx_neg[1] == ~o_serial_tx_pos[1])
	) else $error("downstream ports not on pairs 1 and 2");

	a_release_after_fund: assert property (
		@(posedge i_clk) disable iff (i_reset)
		$rose(o_downstream_port_reset_n[1]) |-> $past(i_fundamental_reset_n, 2)
	) else $error("port 1 reset released while fundamental reset held");

	a_hold_no_early: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(!o_downstream_port_reset_n[1] && g_port[1].u_port.state_r == srrc_pkg::SRRC_ST_HOLD
			&& g_port[1].u_port.cnt_r != '0) |=> !o_downstream_port_reset_n[1]
	) else $error("port 1 reset released before hot-plug hold ended");

	a_plug_port2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		($fell(i_slot_present_n[2]) && !fund_active_r && i_fundamental_reset_n)
			|=> !o_downstream_port_reset_n[2]
	) else $error("port 2 reset not asserted after plug-in");

	a_port_separate2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(i_fundamental_reset_n && !fund_active_r && o_downstream_port_reset_n[1]
			&& $fell(i_slot_present_n[2]) && !$fell(i_slot_present_n[1]))
			|=> o_downstream_port_reset_n[1]
	) else $error("port 2 plug-in disturbed port 1 reset");

	a_sticky_port2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		o_plug_seen[2] |=> o_plug_seen[2]
	) else $error("sticky plug flag 2 lost without power-on reset");

	a_plug_seen_set: assert property (
		@(posedge i_clk) disable iff (i_reset)
		plug_event[1] |=> o_plug_seen[1]
	) else $error("sticky plug flag 1 not set after plug-in");

	a_plug_seen_set2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		plug_event[2] |=> o_plug_seen[2]
	) else $error("sticky plug flag 2 not set after plug-in");

	a_tx_idle_fund: assert property (
		@(posedge i_clk) disable iff (i_reset)
		fund_active_r |=> (o_serial_tx_pos == 4'h0 && o_serial_tx_neg == 4'h0)
	) else $error("transmit pairs not idle under fundamental reset");

	a_release_port2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		$rose(o_downstream_port_reset_n[2]) |-> $past(i_fundamental_reset_n, 2)
	) else $error("port 2 reset released while fundamental reset held");

	a_hold_no_early2: assert property (
		@(posedge i_clk) disable iff (i_reset)
		(!o_downstream_port_reset_n[2] && g_port[2].u_port.state_r == srrc_pkg::SRRC_ST_HOLD
			&& g_port[2].u_port.cnt_r != '0) |=> !o_downstream_port_reset_n[2]
	) else $error("port 2 reset released before hot-plug hold ended");

endmodule

// File: tb/srrc_partner.sv
module srrc_partner (
	input wire logic i_clk,
	input wire logic i_fund_req,
	input wire logic [2:1] i_plugged,
	input wire logic [2:1] i_port_reset_n,
	output logic o_fundamental_reset_n,
	output logic [2:1] o_slot_present_n,
	output logic [2:1][15:0] o_low_len
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:1] prev_r = 2'h3;
	// system reset source: active low level
	assign o_fundamental_reset_n = ~i_fund_req;
	// card presence pin pulls low once seated
	assign o_slot_present_n = ~i_plugged;
	// each downstream device measures how long it was held in reset
	always @(posedge i_clk) begin
		prev_r <= i_port_reset_n;
		for (int x = 1; x <= 2; x++) begin
			if (i_port_reset_n[x] === 1'b0) begin
				o_low_len[x] <= (prev_r[x] === 1'b1) ? 16'h0001 : o_low_len[x] + 16'h0001;
			end
		end
	end
endmodule

// File: tb/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 8;
	logic clk, reset, fund_req, strap, fund_n, core_n, buf_en;
	logic [2:1] plugged, present_n, dsr_n, plug_seen;
	logic [2:0] out_en;
	logic [3:0] txp, txn;
	logic [2:1][15:0] low_len;
	srrc_pkg::srrc_tx_t tx;
	int bad_count, n_checks, cycles;

	srrc_top #(.HOTPLUG_HOLD_CYCLES(HOLD)) i_srrc_top (.i_clk(clk), .i_reset(reset),
		.i_fundamental_reset_n(fund_n), .i_refclk_buffer_powerdown(strap),
		.i_slot_present_n(present_n), .i_tx(tx), .o_core_reset_n(core_n),
		.o_downstream_port_reset_n(dsr_n), .o_plug_seen(plug_seen),
		.o_refclk_buffer_enable(buf_en), .o_refclk_out_enable(out_en),
		.o_serial_tx_pos(txp), .o_serial_tx_neg(txn));
	srrc_partner i_srrc_partner (.i_clk(clk), .i_fund_req(fund_req), .i_plugged(plugged),
		.i_port_reset_n(dsr_n), .o_fundamental_reset_n(fund_n),
		.o_slot_present_n(present_n), .o_low_len(low_len));

	task automatic check(string name, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic t_fund();
		fund_req = 1'b1;
		tick(2);
		check("core_reset_n", 16'h0000, core_n);
		check("port_reset_n", 16'h0000, dsr_n);
		check("tx_pos_idle", 16'h0000, txp);
		fund_req = 1'b0;
		tick(2);
		check("core_reset_n", 16'h0001, core_n);
		check("port_reset_n", 16'h0003, dsr_n);
		$display("test fund done");
	endtask

	task automatic t_strap();
		fund_req = 1'b1;
		strap = 1'b1;
		tick(2);
		fund_req = 1'b0;
		tick(2);
		check("buf_en", 16'h0000, buf_en);
		check("out_en", 16'h0000, out_en);
		strap = 1'b0;
		tick(3);
		check("buf_en_frozen", 16'h0000, buf_en);
		fund_req = 1'b1;
		tick(2);
		fund_req = 1'b0;
		tick(2);
		check("buf_en", 16'h0001, buf_en);
		check("out_en", 16'h0007, out_en);
		$display("test strap done");
	endtask

	task automatic t_plug(int x);
		logic ok;
		plugged[x] = 1'b1;
		tick(2);
		check("port_reset_n_plugged", 16'h0000, dsr_n[x]);
		check("port_reset_n_other", 16'h0001, dsr_n[3 - x]);
		tick(1);
		check("plug_seen", 16'h0001, plug_seen[x]);
		tick(HOLD - 3);
		check("port_reset_n_held", 16'h0000, dsr_n[x]);
		tick(5);
		check("port_reset_n_released", 16'h0001, dsr_n[x]);
		ok = (low_len[x] >= 16'(HOLD)) && (low_len[x] <= 16'(HOLD + 2));
		check("hold_length_ok", 16'h0001, ok);
		plugged[x] = 1'b0;
		tick(2);
		$display("test plug port %0d done", x);
	endtask

	task automatic t_sticky();
		fund_req = 1'b1;
		tick(2);
		check("plug_seen_in_reset", 16'h0003, plug_seen);
		fund_req = 1'b0;
		tick(2);
		check("plug_seen_after", 16'h0003, plug_seen);
		$display("test sticky done");
	endtask

	task automatic t_plug_edge();
		fund_req = 1'b1;
		tick(2);
		fund_req = 1'b0;
		tick(1);
		plugged[1] = 1'b1;
		tick(2);
		check("port_reset_n_edge", 16'h0000, dsr_n[1]);
		check("port_reset_n_edge_other", 16'h0001, dsr_n[2]);
		tick(HOLD + 2);
		check("port_reset_n_edge_end", 16'h0001, dsr_n[1]);
		plugged[1] = 1'b0;
		tick(2);
		$display("test plug at release done");
	endtask

	task automatic t_tx();
		logic [3:0] exp;
		for (int i = 0; i < 4; i++) begin
			tx = srrc_pkg::srrc_tx_t'(4'h1 << i);
			exp = {tx.up_lane[1], tx.dn_port2, tx.dn_port1, tx.up_lane[0]};
			tick(1);
			check("tx_pos", 16'(exp), txp);
			check("tx_neg", {12'h000, ~exp}, txn);
		end
		$display("test tx done");
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			give_verdict();
		end
	end

	initial begin
		reset = 1'b1;
		fund_req = 1'b1;
		strap = 1'b0;
		plugged = 2'h0;
		tx = srrc_pkg::srrc_tx_t'(4'h0);
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		tick(2);
		t_fund();
		t_strap();
		t_plug(1);
		t_plug(2);
		t_sticky();
		t_plug_edge();
		t_tx();
		give_verdict();
	end
endmodule
